// [hw/phyx_bank.sv]
// Extended management register bank of the transceiver
// Summary of operation
// - Quick status mirrors jabber, read keeps it
// - Report negotiation complete and loopback enabled
// - Duplex bit, one is full duplex
// - Speed bit, one is 10 Mb/s
// - Quick status mirrors link, read keeps it
// - False carrier counter saturates, clears on read
// - Receive errors counted once per carrier, no collision
// - True quiet enable drives quiet transmit
// - Signal detect force and algorithm select
// - Descrambler timeout 722 us or 2 ms
// - Force good 100 link, NRZI bypass
// - RMII mode select, strap reset value
// - Revision select controls carrier toggle
// - Receive FIFO overflow and underflow status
// - Elasticity tolerance field, default 01
// - Indicator override drives stored values
// - Auto crossover enable and force cross
// - Pause results only for full duplex
// - Force error injects one error while self-test runs, self-clears
// - Self-test run, sequence select, pass flag
// - Stretch bypass makes indicators direct
// - Indicator config selects link or activity
`timescale 1ns/1ps
`include "phyx_defines.svh"
module phyx_bank #(
	parameter int DESC_SHORT_CYC = (`PHYX_DESC_SHORT_NS + `PHYX_CLK_NS - 1) / `PHYX_CLK_NS,
	parameter int DESC_LONG_CYC = (`PHYX_DESC_LONG_NS + `PHYX_CLK_NS - 1) / `PHYX_CLK_NS,
	parameter int STRETCH_CYC = `PHYX_STRETCH_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic strap_rmii,
	input wire logic strap_auto_crossover_enable,
	input wire logic strap_led_cfg,
	input wire logic jabber_in,
	input wire logic an_complete_in,
	input wire logic an_enable_in,
	input wire logic loopback_in,
	input wire logic link_in,
	input wire logic full_duplex_in,
	input wire logic speed10_in,
	input wire logic mdix_swapped_in,
	input wire logic false_carrier_ev,
	input wire logic carrier_in,
	input wire logic invalid_symbol_in,
	input wire logic collision_in,
	input wire logic rx_fifo_ovf_in,
	input wire logic rx_fifo_unf_in,
	input wire logic [1:0] local_pause_in,
	input wire logic [1:0] partner_pause_in,
	input wire logic activity_in,
	input wire logic bist_error_in,
	input wire logic descrambler_activity_in,
	output logic true_quiet_enable,
	output logic signal_detect_force,
	output logic signal_detect_algorithm,
	output logic descrambler_timeout,
	output logic force_100_link,
	output logic nrzi_bypass,
	output logic rmii_mode,
	output logic old_revision_select,
	output logic [1:0] elasticity_tolerance,
	output logic auto_crossover_enable,
	output logic crossover_force,
	output logic selftest_run,
	output logic selftest_sequence_select,
	output logic selftest_inject_error,
	output logic rate_indicator_pin,
	output logic link_indicator_pin
);
	// Timer is 32 bits and the stretch counter 16 bits; refuse what they cannot hold
	if (DESC_SHORT_CYC < 1 || DESC_LONG_CYC <= DESC_SHORT_CYC || STRETCH_CYC < 1 ||
		STRETCH_CYC > 16'hFFFF) begin : g_bad_timing
		$error("phyx_bank: bad timing parameters");
	end

	logic rst_s1_r;
	logic rst_s2_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_core_n = rst_s2_r;

	// Pins from the line side are synchronised; first stage feeds only the second
	localparam int NSYNC = 18;
	wire [NSYNC-1:0] pin_raw = {jabber_in, an_complete_in, an_enable_in, loopback_in, link_in,
		full_duplex_in, speed10_in, mdix_swapped_in, false_carrier_ev, carrier_in,
		invalid_symbol_in, collision_in, rx_fifo_ovf_in, rx_fifo_unf_in, activity_in,
		bist_error_in, strap_rmii, strap_auto_crossover_enable};
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic strap_led_s1_r;
	logic strap_led_s2_r;
	// Reset from the pin, not the core copy, so straps are settled when captured
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			strap_led_s1_r <= 1'b0;
			strap_led_s2_r <= 1'b0;
		end else begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
			strap_led_s1_r <= strap_led_cfg;
			strap_led_s2_r <= strap_led_s1_r;
		end
	end
	wire s_jab = sync2_r[17];
	wire s_anc = sync2_r[16];
	wire s_ane = sync2_r[15];
	wire s_lpb = sync2_r[14];
	wire s_lnk = sync2_r[13];
	wire s_fd = sync2_r[12];
	wire s_s10 = sync2_r[11];
	wire s_mdx = sync2_r[10];
	wire s_fc = sync2_r[9];
	wire s_crs = sync2_r[8];
	wire s_inv = sync2_r[7];
	wire s_col = sync2_r[6];
	wire s_ovf = sync2_r[5];
	wire s_unf = sync2_r[4];
	wire s_act = sync2_r[3];
	wire s_berr = sync2_r[2];
	wire s_srmii = sync2_r[1];
	wire s_smdix = sync2_r[0];

	// Counters stick at the top rather than wrap
	function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic inc);
		sat_inc = (inc && v != `PHYX_CNT_MAX) ? v + 8'h01 : v;
	endfunction : sat_inc

	// Address decode
	wire sel_qs = reg_addr == `PHYX_OFF_QSTAT;
	wire sel_fc = reg_addr == `PHYX_OFF_FCAR;
	wire sel_re = reg_addr == `PHYX_OFF_RXERR;
	wire sel_cd = reg_addr == `PHYX_OFF_CODING;
	wire sel_rb = reg_addr == `PHYX_OFF_REDIF;
	wire sel_ld = reg_addr == `PHYX_OFF_LEDOV;
	wire sel_pc = reg_addr == `PHYX_OFF_XCVR;
	wire rd_fc = reg_rd && sel_fc;
	wire rd_re = reg_rd && sel_re;

	logic [15:0] coding_r;
	logic [15:0] redif_r;
	logic [15:0] ledov_r;
	logic [15:0] xcvr_r;
	logic [7:0] fc_cnt_r;
	logic [7:0] re_cnt_r;
	logic fc_prev_r;
	logic re_counted_r;
	logic strap_taken_r;

	wire fc_ev = s_fc && !fc_prev_r;
	wire re_ev = s_crs && s_inv && !s_col && !re_counted_r;
	// A read takes the old count; an event in that cycle starts the new one
	// event beside read survives
	wire [7:0] fc_nxt = rd_fc ? {7'h00, fc_ev} : sat_inc(fc_cnt_r, fc_ev);
	wire [7:0] re_nxt = rd_re ? {7'h00, re_ev} : sat_inc(re_cnt_r, re_ev);

	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			fc_cnt_r <= 8'h00;
			re_cnt_r <= 8'h00;
			fc_prev_r <= 1'b0;
			re_counted_r <= 1'b0;
		end else begin
			fc_cnt_r <= fc_nxt;
			re_cnt_r <= re_nxt;
			fc_prev_r <= s_fc;
			// Held until carrier drops, so a burst of bad symbols counts once
			re_counted_r <= s_crs && (re_counted_r || re_ev);
		end
	end

	// Self-test state
	// An error while running drops the pass flag until the next start
	phyx_pkg::phyx_bist_t bist_r;
	phyx_pkg::phyx_bist_t bist_nxt;
	wire bist_on = xcvr_r[`PHYX_B_BSTART];
	always_comb begin
		bist_nxt = bist_r;
		case (bist_r)
			phyx_pkg::PHYX_BI_IDLE: begin
				if (bist_on) begin
					bist_nxt = phyx_pkg::PHYX_BI_RUN;
				end
			end
			phyx_pkg::PHYX_BI_RUN: begin
				if (!bist_on) begin
					bist_nxt = phyx_pkg::PHYX_BI_IDLE;
				end else if (s_berr) begin
					bist_nxt = phyx_pkg::PHYX_BI_FAIL;
				end
			end
			phyx_pkg::PHYX_BI_FAIL: begin
				if (!bist_on) begin
					bist_nxt = phyx_pkg::PHYX_BI_IDLE;
				end
			end
			default: begin
				bist_nxt = phyx_pkg::PHYX_BI_IDLE;
			end
		endcase
	end
	wire bist_pass = bist_r == phyx_pkg::PHYX_BI_RUN;

	// Pause inputs share this clock, so they skip the synchronisers
	// pause resolution, full duplex only
	wire l_p = local_pause_in[0];
	wire l_a = local_pause_in[1];
	wire p_p = partner_pause_in[0];
	wire p_a = partner_pause_in[1];
	wire hcd_fd = s_anc && s_ane && s_fd && s_lnk;
	wire pause_tx = hcd_fd && ((l_p && p_p) || (!l_p && l_a && p_p && p_a));
	wire pause_rx = hcd_fd && ((l_p && p_p) || (l_p && l_a && !p_p && p_a));

	wire [15:0] w_cd = (coding_r & ~`PHYX_CODING_WMASK) | (reg_wdata & `PHYX_CODING_WMASK);
	wire [15:0] w_rb = (redif_r & ~`PHYX_REDIF_WMASK) | (reg_wdata & `PHYX_REDIF_WMASK);
	wire [15:0] w_ld = (ledov_r & ~`PHYX_LEDOV_WMASK) | (reg_wdata & `PHYX_LEDOV_WMASK);
	wire [15:0] w_pc = (xcvr_r & ~`PHYX_XCVR_WMASK) | (reg_wdata & `PHYX_XCVR_WMASK);

	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			coding_r <= `PHYX_CODING_RST;
			redif_r <= {14'h0000, `PHYX_ELAST_RST};
			ledov_r <= 16'h0000;
			xcvr_r <= 16'h0000;
			strap_taken_r <= 1'b0;
			bist_r <= phyx_pkg::PHYX_BI_IDLE;
		end else begin
			bist_r <= bist_nxt;
			// Straps are taken once; a write in that same cycle is lost
			if (!strap_taken_r) begin
				strap_taken_r <= 1'b1;
				redif_r[`PHYX_B_RMII] <= s_srmii;
				xcvr_r[`PHYX_B_MDIXEN] <= s_smdix;
				xcvr_r[`PHYX_B_LEDCFG] <= strap_led_s2_r;
			end else begin
				if (reg_wr && sel_cd) begin
					coding_r <= w_cd;
				end
				if (reg_wr && sel_rb) begin
					redif_r <= w_rb;
				end
				if (reg_wr && sel_ld) begin
					ledov_r <= w_ld;
				end
				if (reg_wr && sel_pc) begin
					xcvr_r <= w_pc;
				end else begin
					xcvr_r[`PHYX_B_BFE] <= 1'b0;
				end
			end
		end
	end

	// one pulse per write of one while self-test start is set
	assign selftest_inject_error = xcvr_r[`PHYX_B_BFE] && bist_on;
	assign selftest_run = bist_on;
	assign selftest_sequence_select = xcvr_r[`PHYX_B_PSR15];
	assign true_quiet_enable = coding_r[`PHYX_B_TQ];
	assign signal_detect_force = coding_r[`PHYX_B_SDF];
	assign signal_detect_algorithm = coding_r[`PHYX_B_SDO];
	assign force_100_link = coding_r[`PHYX_B_F100];
	assign nrzi_bypass = coding_r[`PHYX_B_NRZI];
	assign rmii_mode = redif_r[`PHYX_B_RMII];
	assign old_revision_select = redif_r[`PHYX_B_REV10];
	assign elasticity_tolerance = redif_r[1:0];
	assign auto_crossover_enable = xcvr_r[`PHYX_B_MDIXEN];
	assign crossover_force = xcvr_r[`PHYX_B_FMDIX];

	// descrambler lock watchdog; long timeout keeps lock on jumbo frames
	logic [31:0] desc_cnt_r;
	logic desc_to_r;
	wire [31:0] desc_lim = coding_r[`PHYX_B_DESC] ? DESC_LONG_CYC : DESC_SHORT_CYC;
	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			desc_cnt_r <= 32'h0000_0000;
			desc_to_r <= 1'b0;
		end else if (descrambler_activity_in) begin
			desc_cnt_r <= 32'h0000_0000;
			desc_to_r <= 1'b0;
		end else if (desc_cnt_r >= desc_lim - 32'h0000_0001) begin
			desc_to_r <= 1'b1;
		end else begin
			desc_cnt_r <= desc_cnt_r + 32'h0000_0001;
		end
	end
	assign descrambler_timeout = desc_to_r;

	// Indicator drive; stretching holds short activity pulses visible
	logic [15:0] stretch_r;
	logic rate_pin_r;
	logic link_pin_r;
	wire act_str = s_act || (stretch_r != 16'h0000);
	wire act_v = xcvr_r[`PHYX_B_BPSTR] ? s_act : act_str;
	// good link or blink on activity
	wire link_norm = xcvr_r[`PHYX_B_LEDCFG] ? s_lnk : (s_lnk && !act_v);
	wire rate_norm = s_lnk && !s_s10;
	wire link_drv = ledov_r[`PHYX_B_DRVLNK] ? ledov_r[`PHYX_B_LNKV] : link_norm;
	wire rate_drv = ledov_r[`PHYX_B_DRVSPD] ? ledov_r[`PHYX_B_SPDV] : rate_norm;
	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			stretch_r <= 16'h0000;
			rate_pin_r <= 1'b0;
			link_pin_r <= 1'b0;
		end else begin
			stretch_r <= s_act ? STRETCH_CYC[15:0] :
				(stretch_r != 16'h0000 ? stretch_r - 16'h0001 : 16'h0000);
			rate_pin_r <= rate_drv;
			link_pin_r <= link_drv;
		end
	end
	assign rate_indicator_pin = rate_pin_r;
	assign link_indicator_pin = link_pin_r;

	// Duplex and speed read zero while the mode is unresolved
	// duplex valid only with link and resolved mode
	wire mode_ok = s_lnk && (s_anc || !s_ane);
	// quick status word, reads clear nothing
	wire [15:0] qs_word = {1'b0, s_mdx, 8'h00, s_jab, s_anc, s_lpb,
		mode_ok && s_fd, mode_ok && s_s10, s_lnk};
	wire [15:0] rb_word = {10'h000, redif_r[5:4], s_ovf, s_unf, redif_r[1:0]};
	wire [15:0] pc_word = {xcvr_r[15:14], pause_rx, pause_tx, xcvr_r[11:10], bist_pass,
		xcvr_r[8:0]};
	// Unmapped addresses read zero
	// override register, not pin state
	wire [15:0] rd_mux = sel_qs ? qs_word :
		sel_fc ? {8'h00, fc_cnt_r} :
		sel_re ? {8'h00, re_cnt_r} :
		sel_cd ? coding_r :
		sel_rb ? rb_word :
		sel_ld ? ledov_r :
		sel_pc ? pc_word : 16'h0000;
	logic [15:0] rdata_r;
	always_ff @(posedge clock or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			rdata_r <= rd_mux;
		end
	end
	assign reg_rdata = rdata_r;
endmodule : phyx_bank

// [hw/phyx_defines.svh]
// Offsets, field positions, reset values and timing counts of the extended register bank
`ifndef PHYX_DEFINES_SVH
`define PHYX_DEFINES_SVH
`define PHYX_OFF_QSTAT 5'h10
`define PHYX_OFF_FCAR 5'h14
`define PHYX_OFF_RXERR 5'h15
`define PHYX_OFF_CODING 5'h16
`define PHYX_OFF_REDIF 5'h17
`define PHYX_OFF_LEDOV 5'h18
`define PHYX_OFF_XCVR 5'h19
`define PHYX_CNT_MAX 8'hFF
`define PHYX_CODING_RST 16'h0100
`define PHYX_CODING_WMASK 16'h07A4
`define PHYX_REDIF_WMASK 16'h0033
`define PHYX_LEDOV_WMASK 16'h0036
`define PHYX_XCVR_WMASK 16'hCDA0
`define PHYX_ELAST_RST 2'h1
`define PHYX_B_TQ 10
`define PHYX_B_SDF 9
`define PHYX_B_SDO 8
`define PHYX_B_DESC 7
`define PHYX_B_F100 5
`define PHYX_B_NRZI 2
`define PHYX_B_RMII 5
`define PHYX_B_REV10 4
`define PHYX_B_OVF 3
`define PHYX_B_UNF 2
`define PHYX_B_DRVSPD 5
`define PHYX_B_DRVLNK 4
`define PHYX_B_SPDV 2
`define PHYX_B_LNKV 1
`define PHYX_B_MDIXEN 15
`define PHYX_B_FMDIX 14
`define PHYX_B_PRX 13
`define PHYX_B_PTX 12
`define PHYX_B_BFE 11
`define PHYX_B_PSR15 10
`define PHYX_B_BSTAT 9
`define PHYX_B_BSTART 8
`define PHYX_B_BPSTR 7
`define PHYX_B_LEDCFG 5
`define PHYX_DESC_SHORT_NS 722000
`define PHYX_DESC_LONG_NS 2000000
`define PHYX_CLK_NS 25
`define PHYX_STRETCH_CYC 16'h0FFF
`endif

// [hw/phyx_pkg.sv]
// Types shared by the extended register bank
package phyx_pkg;
	typedef enum logic [1:0] {
		PHYX_EB_14 = 2'h0,
		PHYX_EB_2 = 2'h1,
		PHYX_EB_6 = 2'h2,
		PHYX_EB_10 = 2'h3
	} phyx_elast_t;
	typedef enum logic [2:0] {
		PHYX_BI_IDLE = 3'h1,
		PHYX_BI_RUN = 3'h2,
		PHYX_BI_FAIL = 3'h4
	} phyx_bist_t;
endpackage : phyx_pkg

// [testbench/phyx_bank_properties.sv]
// Port-level properties of the extended register bank
`timescale 1ns/1ps
module phyx_bank_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic descrambler_activity_in,
	input wire logic true_quiet_enable,
	input wire logic signal_detect_force,
	input wire logic signal_detect_algorithm,
	input wire logic descrambler_timeout,
	input wire logic force_100_link,
	input wire logic nrzi_bypass,
	input wire logic rmii_mode,
	input wire logic old_revision_select,
	input wire logic [1:0] elasticity_tolerance,
	input wire logic auto_crossover_enable,
	input wire logic crossover_force,
	input wire logic selftest_run,
	input wire logic selftest_sequence_select,
	input wire logic selftest_inject_error,
	input wire logic rate_indicator_pin
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Forced error write, kept as a wire so past values see one signal
	wire logic fe_wr = reg_wr && reg_addr == 5'h19 && reg_wdata[11];
	sequence s_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	property p_quiet;
		s_wr(5'h16) |-> ##2 true_quiet_enable == $past(reg_wdata[10], 2);
	endproperty
	a_quiet: assert property (p_quiet) else $error("quiet enable wrong");
	property p_coding;
		s_wr(5'h16) |-> ##2 {signal_detect_force, signal_detect_algorithm, force_100_link,
			nrzi_bypass} == {$past(reg_wdata[9:8], 2), $past(reg_wdata[5], 2), $past(reg_wdata[2], 2)};
	endproperty
	a_coding: assert property (p_coding) else $error("coding outputs wrong");
	property p_redif;
		s_wr(5'h17) |-> ##2 {rmii_mode, old_revision_select, elasticity_tolerance}
			== {$past(reg_wdata[5:4], 2), $past(reg_wdata[1:0], 2)};
	endproperty
	a_redif: assert property (p_redif) else $error("reduced interface wrong");
	property p_ledov;
		s_wr(5'h18) ##0 reg_wdata[5] |-> ##2 rate_indicator_pin == $past(reg_wdata[2], 2);
	endproperty
	a_ledov: assert property (p_ledov) else $error("rate override wrong");
	property p_xover;
		s_wr(5'h19) |-> ##2 {auto_crossover_enable, crossover_force} == $past(reg_wdata[15:14], 2);
	endproperty
	a_xover: assert property (p_xover) else $error("crossover wrong");
	property p_bist;
		s_wr(5'h19) |-> ##2 {selftest_run, selftest_sequence_select}
			== {$past(reg_wdata[8], 2), $past(reg_wdata[10], 2)};
	endproperty
	a_bist: assert property (p_bist) else $error("self-test control wrong");
	property p_inject;
		selftest_inject_error |-> selftest_run ##1 !selftest_inject_error;
	endproperty
	a_inject: assert property (p_inject) else $error("inject not single");
	property p_inject_cause;
		$rose(selftest_inject_error) |-> $past(fe_wr);
	endproperty
	a_inject_cause: assert property (p_inject_cause) else $error("inject uncaused");
	property p_desc;
		descrambler_activity_in |-> ##2 !descrambler_timeout;
	endproperty
	a_desc: assert property (p_desc) else $error("timeout during activity");
	property p_rdhold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdhold: assert property (p_rdhold) else $error("read data moved");
endmodule : phyx_bank_chk
bind phyx_bank phyx_bank_chk u_chk (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata, .descrambler_activity_in, .true_quiet_enable, .signal_detect_force,
	.signal_detect_algorithm, .descrambler_timeout, .force_100_link, .nrzi_bypass, .rmii_mode,
	.old_revision_select, .elasticity_tolerance, .auto_crossover_enable, .crossover_force,
	.selftest_run, .selftest_sequence_select, .selftest_inject_error, .rate_indicator_pin);

// [testbench/phyx_sta.sv]
// Management controller model driving the register strobes
`timescale 1ns/1ps
module phyx_sta (
	input wire logic clock,
	input wire logic [15:0] reg_rdata,
	output logic [4:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata
);
	initial begin
		reg_addr = 5'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 16'h0000;
	end
	// Idle lines show inverted values so stale data is never mistaken
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	task rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		reg_addr <= ~a;
		@(posedge clock);
		d = reg_rdata;
	endtask : rd
endmodule : phyx_sta

// [testbench/tb_top.sv]
// Self-checking bench for the extended register bank
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic strap_rmii, strap_auto_crossover_enable, strap_led_cfg, jabber_in, an_complete_in, an_enable_in;
	logic loopback_in, link_in, full_duplex_in, speed10_in, mdix_swapped_in, false_carrier_ev;
	logic carrier_in, invalid_symbol_in, collision_in, rx_fifo_ovf_in, rx_fifo_unf_in;
	logic activity_in, bist_error_in, descrambler_activity_in, reg_wr, reg_rd;
	logic true_quiet_enable, signal_detect_force, signal_detect_algorithm, descrambler_timeout;
	logic force_100_link, nrzi_bypass, rmii_mode, old_revision_select, auto_crossover_enable;
	logic crossover_force, selftest_run, selftest_sequence_select, selftest_inject_error;
	logic rate_indicator_pin, link_indicator_pin;
	logic [1:0] local_pause_in, partner_pause_in, elasticity_tolerance;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	int fail_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #12.5 clock = ~clock;
	// Short counts keep stretch and timeouts within a brief run
	phyx_bank #(.DESC_SHORT_CYC(10), .DESC_LONG_CYC(20), .STRETCH_CYC(4)) DUT (.clock, .rst_n,
		.reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .strap_rmii, .strap_auto_crossover_enable,
		.strap_led_cfg, .jabber_in, .an_complete_in, .an_enable_in, .loopback_in, .link_in,
		.full_duplex_in, .speed10_in, .mdix_swapped_in, .false_carrier_ev, .carrier_in,
		.invalid_symbol_in, .collision_in, .rx_fifo_ovf_in, .rx_fifo_unf_in, .local_pause_in,
		.partner_pause_in, .activity_in, .bist_error_in, .descrambler_activity_in,
		.true_quiet_enable, .signal_detect_force, .signal_detect_algorithm, .descrambler_timeout,
		.force_100_link, .nrzi_bypass, .rmii_mode, .old_revision_select, .elasticity_tolerance,
		.auto_crossover_enable, .crossover_force, .selftest_run, .selftest_sequence_select,
		.selftest_inject_error, .rate_indicator_pin, .link_indicator_pin);
	phyx_sta u_sta (.clock, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
	task end_sim;
		if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task chk(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
		u_sta.rd(a, d);
		chk(d & m, e);
	endtask : rdc
	task pz(input logic [1:0] lp, input logic [1:0] pp, input logic fd, input logic [15:0] e);
		@(posedge clock);
		local_pause_in <= lp;
		partner_pause_in <= pp;
		full_duplex_in <= fd;
		repeat (6) @(posedge clock);
		rdc(5'h19, 16'h3000, e);
	endtask : pz
	task fc(input int n);
		repeat (n) begin
			@(posedge clock);
			false_carrier_ev <= 1'h1;
			repeat (2) @(posedge clock);
			false_carrier_ev <= 1'h0;
			repeat (2) @(posedge clock);
		end
		repeat (4) @(posedge clock);
	endtask : fc
	task rxe(input logic c);
		@(posedge clock);
		collision_in <= c;
		carrier_in <= 1'h1;
		repeat (2) begin
			repeat (3) @(posedge clock);
			invalid_symbol_in <= 1'h1;
			repeat (3) @(posedge clock);
			invalid_symbol_in <= 1'h0;
		end
		repeat (4) @(posedge clock);
		carrier_in <= 1'h0;
		collision_in <= 1'h0;
		repeat (4) @(posedge clock);
	endtask : rxe
	task dsc(input logic e);
		@(posedge clock);
		descrambler_activity_in <= 1'h1;
		@(posedge clock);
		descrambler_activity_in <= 1'h0;
		repeat (15) @(posedge clock);
		chk(16'(descrambler_timeout), 16'(e));
	endtask : dsc
	task act(input logic [15:0] cfg, input logic e);
		u_sta.wr(5'h19, cfg);
		@(posedge clock);
		activity_in <= 1'h1;
		repeat (4) @(posedge clock);
		chk(16'(link_indicator_pin), 16'h0000);
		activity_in <= 1'h0;
		repeat (5) @(posedge clock);
		chk(16'(link_indicator_pin), 16'(e));
	endtask : act
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_sim;
		end
	end
	initial begin
		{strap_rmii, strap_auto_crossover_enable, strap_led_cfg} = 3'h7;
		{jabber_in, an_complete_in, an_enable_in, loopback_in, link_in, full_duplex_in} = '0;
		{speed10_in, mdix_swapped_in, false_carrier_ev, carrier_in, invalid_symbol_in} = '0;
		{collision_in, rx_fifo_ovf_in, rx_fifo_unf_in, activity_in, bist_error_in} = '0;
		descrambler_activity_in = 1'h0;
		local_pause_in = 2'h0;
		partner_pause_in = 2'h0;
		repeat (20) @(posedge clock);
		rst_n <= 1'h1;
		repeat (6) @(posedge clock);
		rdc(5'h16, 16'hFFFF, 16'h0100);
		rdc(5'h17, 16'hFFFF, 16'h0021);
		rdc(5'h18, 16'hFFFF, 16'h0000);
		rdc(5'h19, 16'hFFFF, 16'h8020);
		rdc(5'h11, 16'hFFFF, 16'h0000);
		{jabber_in, an_complete_in, an_enable_in, loopback_in, link_in, full_duplex_in} <= '1;
		mdix_swapped_in <= 1'h1;
		repeat (5) @(posedge clock);
		rdc(5'h10, 16'h403F, 16'h403D);
		pz(2'h1, 2'h1, 1'h1, 16'h3000);
		pz(2'h2, 2'h3, 1'h1, 16'h1000);
		pz(2'h3, 2'h2, 1'h1, 16'h2000);
		pz(2'h1, 2'h1, 1'h0, 16'h0000);
		speed10_in <= 1'h1;
		repeat (5) @(posedge clock);
		rdc(5'h10, 16'h403F, 16'h403B);
		rdc(5'h10, 16'h403F, 16'h403B);
		fc(3);
		rdc(5'h14, 16'hFFFF, 16'h0003);
		rdc(5'h14, 16'hFFFF, 16'h0000);
		fc(260);
		rdc(5'h14, 16'hFFFF, 16'h00FF);
		u_sta.wr(5'h14, 16'hFFFF);
		rdc(5'h14, 16'hFFFF, 16'h0000);
		rxe(1'h0);
		rxe(1'h1);
		rdc(5'h15, 16'hFFFF, 16'h0001);
		u_sta.wr(5'h16, 16'hFFFF);
		rdc(5'h16, 16'hFFFF, 16'h07A4);
		chk(16'({true_quiet_enable, signal_detect_force, signal_detect_algorithm,
			force_100_link, nrzi_bypass}), 16'h001F);
		dsc(1'h0);
		u_sta.wr(5'h16, 16'h0000);
		dsc(1'h1);
		chk(16'({signal_detect_algorithm, true_quiet_enable}), 16'h0000);
		for (int i = 0; i < 4; i++) begin
			u_sta.wr(5'h17, 16'(i));
			rdc(5'h17, 16'hFFFF, 16'(i));
			chk(16'({rmii_mode, old_revision_select, elasticity_tolerance}), 16'(i));
		end
		u_sta.wr(5'h17, 16'hFFFF);
		rdc(5'h17, 16'hFFFF, 16'h0033);
		chk(16'({rmii_mode, old_revision_select}), 16'h0003);
		{rx_fifo_ovf_in, rx_fifo_unf_in} <= 2'h3;
		repeat (5) @(posedge clock);
		rdc(5'h17, 16'h000C, 16'h000C);
		{rx_fifo_ovf_in, rx_fifo_unf_in} <= 2'h0;
		u_sta.wr(5'h18, 16'hFFFF);
		rdc(5'h18, 16'hFFFF, 16'h0036);
		chk(16'({rate_indicator_pin, link_indicator_pin}), 16'h0003);
		u_sta.wr(5'h18, 16'h0030);
		rdc(5'h18, 16'hFFFF, 16'h0030);
		chk(16'({rate_indicator_pin, link_indicator_pin}), 16'h0000);
		u_sta.wr(5'h18, 16'h0000);
		repeat (10) @(posedge clock);
		chk(16'({rate_indicator_pin, link_indicator_pin}), 16'h0001);
		u_sta.wr(5'h19, 16'h4100);
		repeat (8) @(posedge clock);
		rdc(5'h19, 16'hCF00, 16'h4300);
		chk(16'({auto_crossover_enable, crossover_force, selftest_run,
			selftest_sequence_select}), 16'h0006);
		u_sta.wr(5'h19, 16'h4D00);
		rdc(5'h19, 16'h0D00, 16'h0500);
		bist_error_in <= 1'h1;
		repeat (4) @(posedge clock);
		bist_error_in <= 1'h0;
		rdc(5'h19, 16'h0200, 16'h0000);
		u_sta.wr(5'h19, 16'h0000);
		rdc(5'h19, 16'h0300, 16'h0000);
		act(16'h0000, 1'h0);
		act(16'h0080, 1'h1);
		end_sim;
	end
endmodule : tb_top
